// *** rtl/reset_source_defines.vh ***
// Constants for the reset source controller, its watchdog and its missing-clock detector
// Function
// - Supply low: drive pin low, hold core
// - Hold core 12 cycles after pin release
// - Pin reset sets pin_reset_flag on exit
// - Enabled detector resets on missing clock
// - Bit 2 enables detector, reads its flag
// - Bit 5 makes low comparator a reset
// - Bit 5 reads 1 after comparator reset
// - Bit 6 makes low convert-start a reset
// - Bit 6 reads 1 after convert-start reset
// - Internal resets leave the pin alone
// - 21-bit watchdog overflow forces a reset
// - Any reset: watchdog on, interval 111b
// - Key A5 enables and reloads watchdog
// - DE then AD within 4 clocks disables
// - Key FF locks disable, no reload
// - Timeout is four to (3+interval) cycles
// - Interval written when bit 7 zero, readable
// - Watchdog bit 4 reads active state
// - Bit 4 write forces internal reset, flag
// - Bit 3 flags a watchdog reset
// - Bit 1 selects supply monitor when enabled
// - Bit 0 write forces power-on reset, pin low
// - Power-on flag set by power-on, supply and bit 0 resets
// - Supply reset holds pin for 100 ms
`ifndef RESET_SOURCE_DEFINES_VH
`define RESET_SOURCE_DEFINES_VH

// ****************************************
// Register map (index; byte address is four times it)
// ****************************************
`define IDX_RESET_CAUSE   8'hEF
`define IDX_WDOG_CTRL     8'hFF
`define RESET_CAUSE_RST   8'h00
`define WDOG_INTERVAL_RST 3'h7

// ****************************************
// Field positions of reset_cause_and_enable and of the watchdog control register
// ****************************************
`define BIT_PIN   0
`define BIT_POR   1
`define BIT_MCD   2
`define BIT_WDT   3
`define BIT_SW    4
`define BIT_COMP  5
`define BIT_CNV   6
`define BIT_WDOG_ACTIVE 4
`define BIT_WDOG_KEY    7

// ****************************************
// Watchdog key values
// ****************************************
`define KEY_RELOAD 8'hA5
`define KEY_ARM    8'hDE
`define KEY_DISARM 8'hAD
`define KEY_LOCK   8'hFF
`define DISARM_WINDOW 3'h4

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     8
`define MCD_TIMEOUT_NS    100000
`define SUPPLY_TIMEOUT_NS 100000000
`define EXIT_CYCLES       24'h00_000C

`endif

// *** rtl/watchdog_timer.v ***
// Watchdog timer: 21-bit counter with key-write control
`timescale 1ns/1ns
`include "reset_source_defines.vh"
module watchdog_timer (
	// Clock and reset
	input  wire       core_clk,
	input  wire       nrst,
	input  wire       hold,
	// Control register writes
	input  wire       wr_stb,
	input  wire [7:0] wr_data,
	// State
	output reg        active_q,
	output reg  [2:0] interval_q,
	output reg        expire_q
);

	reg [20:0] count_q;   // Cycles since last reload
	reg        lock_q;    // Disable locked out
	reg [2:0]  arm_q;     // Cycles left to finish disable

	// Last count before overflow: 4^(3+n) - 1
	function [20:0] wdog_limit;
		input [2:0] n;
		begin
			wdog_limit = (21'h00_0001 << ({2'b00, n, 1'b0} + 6'h06)) - 21'h00_0001;
		end
	endfunction

	// Counter, keys and interval
	always @(posedge core_clk) begin
		if (!nrst || hold) begin
			count_q    <= 21'h00_0000;
			active_q   <= 1'b1;
			interval_q <= `WDOG_INTERVAL_RST;
			lock_q     <= 1'b0;
			arm_q      <= 3'h0;
			expire_q   <= 1'b0;
		end else begin
			expire_q <= 1'b0;
			if (arm_q != 3'h0)
				arm_q <= arm_q - 3'h1;
			if (active_q) begin
				if (count_q >= wdog_limit(interval_q)) begin
					expire_q <= 1'b1;
					count_q  <= 21'h00_0000;
				end else begin
					count_q <= count_q + 21'h00_0001;
				end
			end
			if (wr_stb) begin
				arm_q <= 3'h0;
				if (!wr_data[`BIT_WDOG_KEY]) begin
					interval_q <= wr_data[2:0];
				end else if (wr_data == `KEY_RELOAD) begin
					active_q <= 1'b1;
					count_q  <= 21'h00_0000;
				end else if (wr_data == `KEY_ARM) begin
					arm_q <= `DISARM_WINDOW;
				end else if (wr_data == `KEY_DISARM && arm_q != 3'h0 && !lock_q) begin
					active_q <= 1'b0;
					count_q  <= 21'h00_0000;
				end else if (wr_data == `KEY_LOCK) begin
					lock_q <= 1'b1;
				end
			end
		end
	end

endmodule // watchdog_timer

// *** rtl/missing_clock_detector.v ***
// Missing-clock detector: times out when the watched clock stops toggling
`timescale 1ns/1ns
module missing_clock_detector #(
	parameter CYCLES = 12500
) (
	// Clock and reset
	input  wire core_clk,
	input  wire nrst,
	// Control and watched clock level (already synchronised)
	input  wire enable,
	input  wire watched_level,
	// Result
	output reg  expire_q
);

	reg [23:0] idle_q;    // Cycles since the last watched edge
	reg        last_q;    // Previous watched level

	// Count idle time, restart on each edge
	always @(posedge core_clk) begin
		if (!nrst) begin
			idle_q   <= 24'h00_0000;
			last_q   <= 1'b0;
			expire_q <= 1'b0;
		end else begin
			last_q   <= watched_level;
			expire_q <= 1'b0;
			if (!enable || watched_level != last_q) begin
				idle_q <= 24'h00_0000;
			end else if ({8'h00, idle_q} >= CYCLES) begin
				expire_q <= 1'b1;
				idle_q   <= 24'h00_0000;
			end else begin
				idle_q <= idle_q + 24'h00_0001;
			end
		end
	end

endmodule // missing_clock_detector

// *** rtl/reset_source_and_watchdog.v ***
// Reset source controller: sequencer, cause register, watchdog and Avalon-MM slave
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "reset_source_defines.vh"
module reset_source_and_watchdog #(
	parameter MCD_CYCLES    = `MCD_TIMEOUT_NS / `CLK_PERIOD_NS,
	parameter SUPPLY_CYCLES = `SUPPLY_TIMEOUT_NS / `CLK_PERIOD_NS
) (
	// Clock and power-on reset
	input  wire        core_clk,
	input  wire        nrst,
	// Avalon-MM slave
	input  wire [9:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Reset sources
	input  wire        supply_below_threshold,
	input  wire        supply_monitor_enable_pin,
	input  wire        rst_pin_in_n,
	input  wire        comparator_output,
	input  wire        convert_start_input_n,
	input  wire        watched_clk_level,
	// Reset outputs
	output reg         sys_rst_n,
	output reg         rst_pin_out,
	output reg         rst_pin_oe_n
);

	// ****************************************
	// Local encodings
	// ****************************************
	localparam [1:0] ST_RUN      = 2'b00;   // Core running
	localparam [1:0] ST_HOLD     = 2'b01;   // Level source still asserted
	localparam [1:0] ST_EXIT     = 2'b10;   // Counting out of reset
	localparam [1:0] ST_PIN_HOLD = 2'b11;   // Power-on style, pin driven

	// Reset causes
	localparam [2:0] C_PIN  = 3'd0;         // Cause codes follow flag bits
	localparam [2:0] C_POR  = 3'd1;
	localparam [2:0] C_MCD  = 3'd2;
	localparam [2:0] C_WDT  = 3'd3;
	localparam [2:0] C_SW   = 3'd4;
	localparam [2:0] C_COMP = 3'd5;
	localparam [2:0] C_CNV  = 3'd6;

	// ****************************************
	// Declarations
	// ****************************************
	reg  [3:0]  sync1_q;                    // First synchroniser stage
	reg  [3:0]  sync2_q;                    // Second synchroniser stage
	reg  [1:0]  state_q;                    // Sequencer state
	reg  [1:0]  state_d;
	reg  [2:0]  cause_q;                    // Cause of the reset in progress
	reg  [2:0]  cause_d;
	reg  [23:0] cnt_q;                      // Exit and pin-hold counter
	reg  [23:0] cnt_d;
	reg         exit_d;                     // Reset ends this cycle
	reg  [7:0]  flags_q;                    // Cause flags seen by reads, bit 7 reserved
	reg  [1:0]  own_drive_q;                // Our pin drive, delayed like the pin
	reg         mcd_en_q;                   // Missing-clock detector enable
	reg         comp_en_q;                  // Comparator reset enable
	reg         cnv_en_q;                   // Convert-start reset enable
	reg         mon_sel_q;                  // Supply monitor selected
	reg         sw_force_q;                 // Software internal reset request
	reg         sw_por_q;                   // Software power-on reset request
	reg         wait_q;                     // Waitrequest state
	reg  [31:0] rdata_d;                    // Read mux result
	reg         source_active;              // Held level source still low
	wire        pin_low;                    // Synchronised pin asserted
	wire        comp_low;                   // Synchronised comparator low
	wire        cnv_low;                    // Synchronised convert-start low
	wire        watched_sync;               // Synchronised watched clock
	wire        supply_fault;               // Supply monitor asking for reset
	wire        bus_take;                   // Access completes this edge
	wire        hit_cause;                  // Address hits cause register
	wire        hit_wdog;                   // Address hits watchdog control
	wire        wdog_wr;                    // Watchdog control write strobe
	wire        wdog_active;
	wire [2:0]  wdog_interval;
	wire        wdog_expire;
	wire        mcd_expire;

	// One-hot flag pattern for a cause code
	function [6:0] cause_flags;
		input [2:0] c;
		begin
			cause_flags = 7'h00;
			cause_flags[c] = 1'b1;
		end
	endfunction

	// Register decode: word index at byte address index*4
	function reg_hit;
		input [9:0] addr;
		input [7:0] idx;
		begin
			reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
		end
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************

	// Two flip-flops on the pin, comparator, convert-start and watched clock inputs
	always @(posedge core_clk) begin
		if (!nrst) begin
			sync1_q <= 4'b0111;
			sync2_q <= 4'b0111;
		end else begin
			sync1_q <= {watched_clk_level, convert_start_input_n, comparator_output, rst_pin_in_n};
			sync2_q <= sync1_q;
		end
	end

	// The pin reads low for two cycles after we stop driving it;
	// this copy of our drive passes the same two stages to mask that
	always @(posedge core_clk) begin
		if (!nrst)
			own_drive_q <= 2'b11;
		else
			own_drive_q <= {own_drive_q[0], ~rst_pin_oe_n};
	end

	assign pin_low      = ~sync2_q[0] & ~own_drive_q[1];
	assign comp_low     = ~sync2_q[1];     // Positive input below negative
	assign cnv_low      = ~sync2_q[2];
	assign watched_sync = sync2_q[3];

	// Monitor acts only while its enable pin is high and it is selected
	assign supply_fault = supply_monitor_enable_pin & mon_sel_q & supply_below_threshold;

	// ****************************************
	// Watchdog and missing-clock detector
	// ****************************************
	// Watchdog stays cleared while the core is in reset
	watchdog_timer u_wdog (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.hold       (state_q != ST_RUN),
		.wr_stb     (wdog_wr),
		.wr_data    (avs_writedata[7:0]),
		.active_q   (wdog_active),
		.interval_q (wdog_interval),
		.expire_q   (wdog_expire)
	);

	// Detector runs only while the core runs
	missing_clock_detector #(
		.CYCLES (MCD_CYCLES)
	) u_mcd (
		.core_clk      (core_clk),
		.nrst          (nrst),
		.enable        (mcd_en_q && state_q == ST_RUN),
		.watched_level (watched_sync),
		.expire_q      (mcd_expire)
	);

	// ****************************************
	// Reset sequencer
	// ****************************************

	// Is the level source behind the held reset still asserted
	always @* begin
		case (cause_q)
			C_PIN:   source_active = pin_low;
			C_COMP:  source_active = comp_low && comp_en_q;
			C_CNV:   source_active = cnv_low && cnv_en_q;
			// Internal causes have no level to wait for
			default: source_active = 1'b0;
		endcase
	end

	// Next state, cause and counter
	always @* begin
		state_d = state_q;
		cause_d = cause_q;
		cnt_d   = cnt_q;
		exit_d  = 1'b0;
		if (supply_fault || sw_por_q) begin
			// Supply drop or software power-on reset restart the pin hold
			state_d = ST_PIN_HOLD;
			cause_d = C_POR;
			cnt_d   = 24'h00_0000;
		end else begin
			case (state_q)
				ST_RUN: begin
					cnt_d = 24'h00_0000;
					// Highest priority source wins
					if (pin_low) begin
						state_d = ST_HOLD;
						cause_d = C_PIN;
					end else if (mcd_expire) begin
						state_d = ST_EXIT;
						cause_d = C_MCD;
					end else if (wdog_expire) begin
						state_d = ST_EXIT;
						cause_d = C_WDT;
					end else if (comp_low && comp_en_q) begin
						state_d = ST_HOLD;
						cause_d = C_COMP;
					end else if (cnv_low && cnv_en_q) begin
						state_d = ST_HOLD;
						cause_d = C_CNV;
					end else if (sw_force_q) begin
						state_d = ST_EXIT;
						cause_d = C_SW;
					end
				end
				ST_HOLD: begin
					// Level sources keep the core in reset while asserted
					if (!source_active) begin
						state_d = ST_EXIT;
						cnt_d   = 24'h00_0000;
					end
				end
				ST_EXIT: begin
					// A new pin press restarts the hold
					if (pin_low) begin
						state_d = ST_HOLD;
						cause_d = C_PIN;
						cnt_d   = 24'h00_0000;
					end else if (cnt_q == `EXIT_CYCLES - 24'h00_0001) begin
						state_d = ST_RUN;
						exit_d  = 1'b1;
					end else begin
						cnt_d = cnt_q + 24'h00_0001;
					end
				end
				ST_PIN_HOLD: begin
					// Pin stays low for the supply timeout after recovery
					if ({8'h00, cnt_q} >= SUPPLY_CYCLES - 1) begin
						state_d = ST_EXIT;
						cnt_d   = 24'h00_0000;
					end else begin
						cnt_d = cnt_q + 24'h00_0001;
					end
				end
				default: begin
					// Unused code: restart as after power-on
					state_d = ST_PIN_HOLD;
					cause_d = C_POR;
					cnt_d   = 24'h00_0000;
				end
			endcase
		end
	end

	// Sequencer registers, flags and reset outputs
	always @(posedge core_clk) begin
		if (!nrst) begin
			// Power-on: hold the pin and the core
			state_q      <= ST_PIN_HOLD;
			cause_q      <= C_POR;
			cnt_q        <= 24'h00_0000;
			flags_q      <= `RESET_CAUSE_RST;
			sys_rst_n    <= 1'b0;
			rst_pin_out  <= 1'b0;
			rst_pin_oe_n <= 1'b0;
		end else begin
			// Counter and cause advance every cycle
			state_q     <= state_d;
			cause_q     <= cause_d;
			cnt_q       <= cnt_d;
			rst_pin_out <= 1'b0;
			// Only the power-on style hold drives the pin
			rst_pin_oe_n <= (state_d != ST_PIN_HOLD);
			sys_rst_n    <= (state_d == ST_RUN);
			// Flags show only the cause of the reset just left
			if (exit_d)
				flags_q <= {1'b0, cause_flags(cause_q)};
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	assign hit_cause = reg_hit(avs_address, `IDX_RESET_CAUSE);
	assign hit_wdog  = reg_hit(avs_address, `IDX_WDOG_CTRL);
	assign bus_take  = (avs_read || avs_write) && !wait_q;
	// Writes land only with byte lane 0 enabled
	assign wdog_wr   = bus_take && avs_write && avs_byteenable[0] && hit_wdog;

	// Read data for the addressed register; unmapped reads return zero
	always @* begin
		rdata_d = 32'h0000_0000;
		if (hit_cause) begin
			// Bit 7 is reserved and reads zero
			rdata_d[7:0] = flags_q;
		end else if (hit_wdog) begin
			rdata_d[2:0]              = wdog_interval;
			rdata_d[`BIT_WDOG_ACTIVE] = wdog_active;
		end
	end

	// Waitrequest, read data and software-written controls
	always @(posedge core_clk) begin
		if (!nrst) begin
			wait_q          <= 1'b1;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			mcd_en_q        <= 1'b0;
			comp_en_q       <= 1'b0;
			cnv_en_q        <= 1'b0;
			mon_sel_q       <= 1'b1;
			sw_force_q      <= 1'b0;
			sw_por_q        <= 1'b0;
		end else begin
			sw_force_q <= 1'b0;
			sw_por_q   <= 1'b0;
			// Enables return to zero with every reset exit
			if (exit_d) begin
				mcd_en_q  <= 1'b0;
				comp_en_q <= 1'b0;
				cnv_en_q  <= 1'b0;
			end
			// One wait cycle per access, then the answer
			if ((avs_read || avs_write) && wait_q) begin
				// First cycle of an access: prepare the answer
				wait_q          <= 1'b0;
				avs_waitrequest <= 1'b0;
				avs_readdata    <= rdata_d;
			end else begin
				// Second cycle: the access completes, writes land here
				wait_q          <= 1'b1;
				avs_waitrequest <= 1'b1;
				if (bus_take && avs_write && avs_byteenable[0] && hit_cause) begin
					// Enables are plain bits, force bits one-cycle pulses
					mcd_en_q  <= avs_writedata[`BIT_MCD];
					comp_en_q <= avs_writedata[`BIT_COMP];
					cnv_en_q  <= avs_writedata[`BIT_CNV];
					if (avs_writedata[`BIT_SW])
						sw_force_q <= 1'b1;
					if (avs_writedata[`BIT_PIN])
						sw_por_q <= 1'b1;
					if (supply_monitor_enable_pin)
						mon_sel_q <= avs_writedata[`BIT_POR];
				end
			end
		end
	end

endmodule // reset_source_and_watchdog

// *** sim/reset_checker.sv ***
// Port assertions for the reset source controller
`timescale 1ns/1ns
`include "reset_source_defines.vh"
module reset_checker #(
	parameter MCD_CYCLES    = 20,
	parameter SUPPLY_CYCLES = 16
) (
	// Clock, reset and bus
	input wire        core_clk,
	input wire        nrst,
	input wire [9:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// Sources and outputs
	input wire        supply_below_threshold,
	input wire        supply_monitor_enable_pin,
	input wire        rst_pin_in_n,
	input wire        sys_rst_n,
	input wire        rst_pin_out,
	input wire        rst_pin_oe_n
);
	// ****************************************
	// Helpers
	// ****************************************
	wire       done_w  = !avs_waitrequest;                // Access completes
	wire       cause_w = avs_write && done_w && avs_byteenable[0] && avs_address == {`IDX_RESET_CAUSE, 2'b00};
	wire       sup_low = supply_below_threshold && supply_monitor_enable_pin;
	wire       por_wr  = cause_w && avs_writedata[0];    // Forced power-on
	wire       sw_wr   = cause_w && avs_writedata[4];    // Forced internal
	wire       mapped  = avs_address == {`IDX_RESET_CAUSE, 2'b00} || avs_address == {`IDX_WDOG_CTRL, 2'b00};
	reg  [2:0] por_age_q;                                 // Cycles since a pin-driving cause
	reg [31:0] oe_run_q;                                  // Cycles the pin has been driven
	// Age and run counters, saturating age
	always @(posedge core_clk) begin
		por_age_q <= (por_wr || sup_low || !nrst) ? 3'h0 : (por_age_q == 3'h7 ? 3'h7 : por_age_q + 3'h1);
		oe_run_q  <= (rst_pin_oe_n || !nrst) ? 32'h0 : oe_run_q + 32'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ****************************************
	// Assertions
	// ****************************************
	a_supply_pin_low: assert property (sup_low |-> ##[1:4] (!rst_pin_oe_n && !sys_rst_n))
		else $error("supply low did not drive pin and core reset");
	a_pin_exit_hold: assert property ($rose(rst_pin_in_n) && $past(rst_pin_oe_n) && !sys_rst_n
		|=> !sys_rst_n [*8] ##1 !sys_rst_n [*4])
		else $error("core left reset too soon after pin release");
	a_pin_quiet_internal: assert property ($fell(rst_pin_oe_n) |-> por_age_q < 3'h4)
		else $error("pin driven by an internal reset");
	a_pin_hold_time: assert property ($rose(rst_pin_oe_n) |-> oe_run_q >= SUPPLY_CYCLES)
		else $error("pin released before the supply timeout");
	a_soft_force: assert property (sw_wr |-> ##[1:3] (!sys_rst_n && rst_pin_oe_n))
		else $error("software force gave no internal reset");
	a_por_force: assert property (por_wr |-> ##[1:3] (!sys_rst_n && !rst_pin_oe_n))
		else $error("forced power-on did not drive the pin");
	a_drive_level: assert property (!rst_pin_oe_n |-> !rst_pin_out)
		else $error("pin driven high");
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> done_w)
		else $error("bus answer late");
	a_wait_pulse: assert property (done_w |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_read_unused: assert property (avs_read && done_w |-> avs_readdata[31:7] == 25'h0)
		else $error("unused read bits set");
	a_unmapped_zero: assert property (avs_read && done_w && !mapped |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	// Main scenarios reached
	c_soft: cover property (sw_wr);
	c_pin: cover property ($rose(rst_pin_in_n) && !sys_rst_n);
	c_supply: cover property (sup_low);
endmodule // reset_checker
bind reset_source_and_watchdog reset_checker #(.MCD_CYCLES(MCD_CYCLES), .SUPPLY_CYCLES(SUPPLY_CYCLES)) u_reset_checker (
	.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .supply_below_threshold(supply_below_threshold),
	.supply_monitor_enable_pin(supply_monitor_enable_pin), .rst_pin_in_n(rst_pin_in_n), .sys_rst_n(sys_rst_n),
	.rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n));

// *** sim/ext_reset_circuit.sv ***
// Board model: pulled-up reset pin, push button and watched clock
`timescale 1ns/1ns
module ext_reset_circuit (
	// Clock and device drive
	input  wire core_clk,
	input  wire rst_pin_out,
	input  wire rst_pin_oe_n,
	// Board controls
	input  wire push_n,
	input  wire clk_run,
	// Wire levels
	output wire rst_pin_in_n,
	output reg  watched_clk_level
);
	// Pull-up wins unless the device or the button pulls low
	assign rst_pin_in_n = !((!rst_pin_oe_n && !rst_pin_out) || !push_n);
	initial watched_clk_level = 1'b0;
	// Watched clock toggles while running, stands still when stopped
	always @(posedge core_clk) begin
		if (clk_run) begin
			watched_clk_level <= ~watched_clk_level;
		end
	end
endmodule // ext_reset_circuit

// *** sim/tb_reset_source_and_watchdog.sv ***
// Self-checking bench for the reset source controller
`timescale 1ns/1ns
`include "reset_source_defines.vh"
module tb_reset_source_and_watchdog;
	reg         core_clk = 1'b0;
	reg         nrst = 1'b0;
	reg  [9:0]  avs_address = 10'h000;
	reg         avs_read = 1'b0;
	reg         avs_write = 1'b0;
	reg  [31:0] avs_writedata = 32'h0000_0000;
	reg  [3:0]  avs_byteenable = 4'hF;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	reg         supply_below_threshold = 1'b0;
	reg         comparator_output = 1'b1;
	reg         convert_start_input_n = 1'b1;
	reg         push_n = 1'b1;
	reg         clk_run = 1'b1;
	wire        rst_pin_in_n, watched_clk_level, sys_rst_n, rst_pin_out, rst_pin_oe_n;
	integer     err_total = 0, n_checks = 0, k, cyc = 0, t0;
	integer     drv = 0, d0;
	reg  [31:0] rd;
	reg  [2:0]  iv;
	always #4 core_clk = ~core_clk;
	// Cycle count and pin drive watch
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (!rst_pin_oe_n) drv <= drv + 1;
	end
	reset_source_and_watchdog #(.MCD_CYCLES(20), .SUPPLY_CYCLES(16)) u_reset_source_and_watchdog (
		.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.supply_below_threshold(supply_below_threshold), .supply_monitor_enable_pin(1'b1),
		.rst_pin_in_n(rst_pin_in_n), .comparator_output(comparator_output),
		.convert_start_input_n(convert_start_input_n), .watched_clk_level(watched_clk_level),
		.sys_rst_n(sys_rst_n), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n));
	ext_reset_circuit u_ext_reset_circuit (.core_clk(core_clk), .rst_pin_out(rst_pin_out),
		.rst_pin_oe_n(rst_pin_oe_n), .push_n(push_n), .clk_run(clk_run),
		.rst_pin_in_n(rst_pin_in_n), .watched_clk_level(watched_clk_level));
	// Expected cause flags and watchdog read value
	function [7:0] cause_code(input integer c);
		cause_code = (c == 7) ? 8'h02 : (8'h01 << c);
	endfunction
	function [7:0] wd_val(input act, input [2:0] i);
		wd_val = {3'b000, act, 1'b0, i};
	endfunction
	task check(input [31:0] seen, input [31:0] exp, input string what);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("unexpected %s: expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// One bus access, held until waitrequest is sampled low
	task bus(input wr, input [7:0] idx, input [7:0] wd);
		integer n;
		begin
			n = 0;
			@(posedge core_clk);
			avs_address <= {idx, 2'b00};
			avs_writedata <= {24'h00_0000, wd};
			avs_read <= !wr;
			avs_write <= wr;
			@(posedge core_clk);
			while (avs_waitrequest !== 1'b0 && n < 50) begin
				@(posedge core_clk);
				n = n + 1;
			end
			check(n < 50, 1, "bus answer");
			rd = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task rdchk(input [7:0] idx, input [7:0] exp);
		begin
			bus(1'b0, idx, 8'h00);
			check(rd, {24'h00_0000, exp}, "register read");
		end
	endtask
	// Wait through one whole core reset
	task ride_reset;
		integer n;
		begin
			n = 0;
			while (sys_rst_n !== 1'b0 && n < 300) begin
				@(posedge core_clk);
				n = n + 1;
			end
			while (sys_rst_n !== 1'b1 && n < 600) begin
				@(posedge core_clk);
				n = n + 1;
			end
			check(n < 600, 1, "reset exit");
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// Watchdog on the run length
	initial begin
		repeat (30000) @(posedge core_clk);
		err_total = err_total + 1;
		give_verdict;
	end
	initial begin
		void'($urandom(32'h806e));
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		ride_reset;
		rdchk(`IDX_RESET_CAUSE, 8'h02);
		rdchk(`IDX_WDOG_CTRL, wd_val(1'b1, 3'h7));
		// Interval written only with bit 7 low
		repeat (4) begin
			iv = $urandom % 8;
			bus(1'b1, `IDX_WDOG_CTRL, {5'h00, iv});
			bus(1'b1, `IDX_WDOG_CTRL, 8'h82);
			rdchk(`IDX_WDOG_CTRL, wd_val(1'b1, iv));
		end
		avs_byteenable <= 4'hE;
		bus(1'b1, `IDX_WDOG_CTRL, 8'h03);
		avs_byteenable <= 4'hF;
		rdchk(`IDX_WDOG_CTRL, wd_val(1'b1, iv));
		rdchk(8'h10, 8'h00);
		bus(1'b1, 8'h10, $urandom);
		rdchk(8'h10, 8'h00);
		$display("test registers done");
		// Disable pair too far apart, then back to back
		bus(1'b1, `IDX_WDOG_CTRL, 8'h07);
		bus(1'b1, `IDX_WDOG_CTRL, `KEY_ARM);
		repeat (6) @(posedge core_clk);
		bus(1'b1, `IDX_WDOG_CTRL, `KEY_DISARM);
		rdchk(`IDX_WDOG_CTRL, wd_val(1'b1, 3'h7));
		bus(1'b1, `IDX_WDOG_CTRL, `KEY_ARM);
		bus(1'b1, `IDX_WDOG_CTRL, `KEY_DISARM);
		rdchk(`IDX_WDOG_CTRL, wd_val(1'b0, 3'h7));
		bus(1'b1, `IDX_WDOG_CTRL, `KEY_RELOAD);
		rdchk(`IDX_WDOG_CTRL, wd_val(1'b1, 3'h7));
		// Regular reloads keep a 64-cycle watchdog quiet
		bus(1'b1, `IDX_WDOG_CTRL, 8'h00);
		repeat (5) begin
			repeat (30) @(posedge core_clk);
			bus(1'b1, `IDX_WDOG_CTRL, `KEY_RELOAD);
		end
		rdchk(`IDX_RESET_CAUSE, 8'h02);
		bus(1'b1, `IDX_WDOG_CTRL, 8'h07);
		$display("test watchdog keys done");
		// Every reset cause in turn
		for (k = 0; k < 8; k = k + 1) begin
			d0 = drv;
			case (k)
				0: begin
					push_n <= 1'b0;
					repeat (3 + $urandom % 6) @(posedge core_clk);
					push_n <= 1'b1;
				end
				1: bus(1'b1, `IDX_RESET_CAUSE, 8'h03);
				2: begin
					bus(1'b1, `IDX_RESET_CAUSE, 8'h06);
					clk_run <= 1'b0;
				end
				3: begin
					bus(1'b1, `IDX_WDOG_CTRL, 8'h00);
					bus(1'b1, `IDX_WDOG_CTRL, `KEY_RELOAD);
					t0 = cyc;
					repeat (10) @(posedge core_clk);
					bus(1'b1, `IDX_WDOG_CTRL, `KEY_LOCK);
					bus(1'b1, `IDX_WDOG_CTRL, `KEY_ARM);
					bus(1'b1, `IDX_WDOG_CTRL, `KEY_DISARM);
					while (sys_rst_n === 1'b1 && cyc - t0 < 200) @(posedge core_clk);
					check(cyc - t0 >= 62 && cyc - t0 <= 70, 1, "watchdog span");
				end
				4: bus(1'b1, `IDX_RESET_CAUSE, 8'h12);
				5, 6: begin
					bus(1'b1, `IDX_RESET_CAUSE, (k == 5) ? 8'h22 : 8'h42);
					comparator_output <= (k != 5);
					convert_start_input_n <= (k != 6);
					repeat (5) @(posedge core_clk);
					comparator_output <= 1'b1;
					convert_start_input_n <= 1'b1;
				end
				default: begin
					supply_below_threshold <= 1'b1;
					repeat (10) @(posedge core_clk);
					supply_below_threshold <= 1'b0;
				end
			endcase
			ride_reset;
			clk_run <= 1'b1;
			rdchk(`IDX_RESET_CAUSE, cause_code(k));
			check(drv != d0, k == 1 || k == 7, "pin drive");
			rdchk(`IDX_WDOG_CTRL, wd_val(1'b1, 3'h7));
			$display("test cause %0d done", k);
		end
		give_verdict;
	end
endmodule // tb_reset_source_and_watchdog
